// file: verilog/adc_seq_pkg.sv
/*
  Shared constants for the converter sequencing block: register indices,
  field positions, reset values, mode encodings and cycle counts.
  Assumes a 32-bit AHB-Lite bus; byte address of a register is four times its index.
*/
package adc_seq_pkg;
  // register indices (byte address = index * 4)
  localparam logic [9:0] IDX_CTRL2 = 10'h3d4;
  localparam logic [9:0] IDX_STATUS = 10'h3d5;
  localparam logic [9:0] IDX_CTRL0 = 10'h3d6;
  localparam logic [9:0] IDX_CTRL1 = 10'h3d7;
  localparam logic [5:0] IDX_RESULT_HI = 6'h3c; // results at 0x3c0..0x3cf, even/odd pairs
  // control 0 fields
  localparam int CH_LSB = 0; // [2:0] input select
  localparam int MODE_LSB = 3; // [5:3] operating mode
  localparam int EXT_BIT = 6; // external trigger select
  localparam int START_BIT = 7; // conversion start flag
  // control 1 fields
  localparam int SWEEP_LSB = 0; // [1:0] sweep group select
  localparam int RES10_BIT = 3; // 1 = 10-bit resolution
  localparam int VREF_BIT = 5; // ladder connect
  localparam int CLKSEL_LSB = 6; // [7:6] operating clock select
  // control 2 fields
  localparam int SH_BIT = 0; // sample-and-hold enable
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic CTRL2_RST = 1'b0;
  // conversion cycle counts in converter clock cycles
  localparam logic [6:0] CYC_8 = 7'd49;
  localparam logic [6:0] CYC_10 = 7'd59;
  localparam logic [6:0] CYC_SH_8 = 7'd28;
  localparam logic [6:0] CYC_SH_10 = 7'd33;

  typedef enum logic [2:0] {
    MODE_ONESHOT, MODE_REPEAT, MODE_SWEEP, MODE_RSWEEP0, MODE_RSWEEP1
  } mode_type;

  typedef enum logic [1:0] {CLK_DIV1, CLK_DIV2, CLK_DIV4, CLK_XIN} clksel_type;
endpackage

// file: verilog/adc_seq.sv
/*
  Sequencing and control for a shared 10-bit successive-approximation converter
  serving eight analog inputs, with an AHB-Lite register slave (zero wait states).
  Assumes the analog engine runs on conv_tick, starts on sar_go and presents
  its result on sar_result by the end of the cycle count; trigger and xin pins
  are asynchronous and are synchronised here.
*/
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module adc_seq
  import adc_seq_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic conv_ext_trigger,
  input wire logic conv_xin,
  input wire logic [9:0] sar_result,
  output logic [2:0] analog_sel,
  output logic sar_go,
  output logic sar_sh,
  output logic sar_res10,
  output logic conv_tick,
  output logic vref_connect,
  output logic conv_irq
);

  if (NUM_CH != 8) begin : g_bad_ch
    $error("adc_seq serves exactly eight inputs");
  end

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic sh;
    logic [7:0][9:0] res;
    logic busy;
    logic [2:0] ch;
    logic [2:0] emph;
    logic [2:0] other;
    logic [6:0] cnt;
    logic [1:0] div;
    logic trig_m, trig_s, trig_d;
    logic xin_m, xin_s, xin_d;
    logic [9:0] dat_m, dat_s;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
    logic irq;
    logic go;
    logic tick;
  } st_type;

  st_type st_r, st_nxt;

  // conversion length in converter clocks for the current setup
  function automatic logic [6:0] conv_cycles(input logic sh, input logic res10);
    if (sh) begin
      conv_cycles = res10 ? CYC_SH_10 : CYC_SH_8;
    end else begin
      conv_cycles = res10 ? CYC_10 : CYC_8;
    end
  endfunction

  // number of inputs in a sweep group: 2, 4, 6 or 8
  function automatic logic [3:0] group_len(input logic [1:0] sel);
    group_len = {1'b0, sel, 1'b0} + 4'd2;
  endfunction

  mode_type mode;
  clksel_type clksel;
  logic ext_sel, start_flag, res10, addr_ok, wr_ctrl0, fall, last, begin_conv;
  logic [9:0] rd_idx;
  logic [6:0] cyc;
  logic [2:0] emph_top, first_ch;
  logic [9:0] stored;

  always_comb begin
    mode = mode_type'(st_r.ctrl0[MODE_LSB +: 3]);
    clksel = clksel_type'(st_r.ctrl1[CLKSEL_LSB +: 2]);
    ext_sel = st_r.ctrl0[EXT_BIT];
    start_flag = st_r.ctrl0[START_BIT];
    res10 = st_r.ctrl1[RES10_BIT];
    cyc = conv_cycles(st_r.sh, res10);
    emph_top = {1'b0, st_r.ctrl1[SWEEP_LSB +: 2]};
    first_ch = (mode == MODE_ONESHOT || mode == MODE_REPEAT) ? st_r.ctrl0[CH_LSB +: 3] : 3'd0;
    addr_ok = hsel && hready && htrans[1];
    rd_idx = haddr[11:2];
    wr_ctrl0 = st_r.wr_pend && st_r.wr_idx == IDX_CTRL0;
    fall = st_r.trig_d && !st_r.trig_s; // only second and third stages are read
    // 8-bit mode keeps the upper eight of ten bits in the even byte
    stored = res10 ? st_r.dat_s : {2'b00, st_r.dat_s[9:2]};
    last = 1'b0;
    begin_conv = 1'b0;
    st_nxt = st_r;
    st_nxt.trig_m = conv_ext_trigger;
    st_nxt.trig_s = st_r.trig_m;
    st_nxt.trig_d = st_r.trig_s;
    st_nxt.xin_m = conv_xin;
    st_nxt.xin_s = st_r.xin_m;
    st_nxt.xin_d = st_r.xin_s;
    st_nxt.dat_m = sar_result;
    st_nxt.dat_s = st_r.dat_m;
    st_nxt.irq = 1'b0;
    st_nxt.go = 1'b0;
    st_nxt.wr_pend = addr_ok && hwrite;
    st_nxt.wr_idx = rd_idx;
    st_nxt.div = st_r.div + 2'd1;
    // operating clock enable for the analog engine
    case (clksel)
      CLK_DIV1: st_nxt.tick = 1'b1;
      CLK_DIV2: st_nxt.tick = st_r.div[0];
      CLK_DIV4: st_nxt.tick = &st_r.div;
      CLK_XIN: st_nxt.tick = st_r.xin_s && !st_r.xin_d;
      default: st_nxt.tick = 1'b0;
    endcase
    // count converter clocks, store the result and pick the next input
    if (st_r.busy && st_r.tick) begin
      st_nxt.cnt = st_r.cnt + 7'd1;
      if (st_r.cnt == cyc - 7'd1) begin
        st_nxt.res[st_r.ch] = stored;
        st_nxt.cnt = 7'd0;
        st_nxt.go = 1'b1;
        case (mode)
          MODE_ONESHOT: last = 1'b1;
          MODE_REPEAT: st_nxt.ch = st_r.ch;
          MODE_SWEEP: begin
            last = {1'b0, st_r.ch} + 4'd1 == group_len(st_r.ctrl1[SWEEP_LSB +: 2]);
            st_nxt.ch = st_r.ch + 3'd1;
          end
          MODE_RSWEEP0: begin
            if ({1'b0, st_r.ch} + 4'd1 == group_len(st_r.ctrl1[SWEEP_LSB +: 2])) begin
              st_nxt.ch = 3'd0;
            end else begin
              st_nxt.ch = st_r.ch + 3'd1;
            end
          end
          MODE_RSWEEP1: begin
            // emphasis inputs in turn, then one of the rest; emph 7 marks a rest input
            if (st_r.emph == 3'd7) begin
              st_nxt.emph = 3'd0;
              st_nxt.ch = 3'd0;
            end else if (st_r.emph < emph_top) begin
              st_nxt.emph = st_r.emph + 3'd1;
              st_nxt.ch = st_r.emph + 3'd1;
            end else begin
              st_nxt.emph = 3'd7;
              st_nxt.ch = st_r.other;
              st_nxt.other = (st_r.other == 3'd7) ? emph_top + 3'd1 : st_r.other + 3'd1;
            end
          end
          default: last = 1'b1;
        endcase
        if (last) begin
          st_nxt.busy = 1'b0;
          st_nxt.go = 1'b0;
          st_nxt.irq = 1'b1;
          if (!ext_sel) begin
            st_nxt.ctrl0[START_BIT] = 1'b0;
          end
        end
      end
    end
    // bus writes land after the hardware update so software wins
    if (st_r.wr_pend) begin
      if (st_r.wr_idx == IDX_CTRL1) begin
        st_nxt.ctrl1 = hwdata[7:0];
      end
      if (st_r.wr_idx == IDX_CTRL2) begin
        st_nxt.sh = hwdata[SH_BIT];
      end
      if (wr_ctrl0) begin
        st_nxt.ctrl0 = hwdata[7:0];
        if (!hwdata[START_BIT]) begin
          st_nxt.busy = 1'b0;
          st_nxt.go = 1'b0;
        end else if (!start_flag && !hwdata[EXT_BIT]) begin
          begin_conv = 1'b1;
        end
      end
    end
    // a falling trigger restarts even a running conversion
    if (ext_sel && start_flag && fall && !(wr_ctrl0 && !hwdata[START_BIT])) begin
      begin_conv = 1'b1;
    end
    if (begin_conv) begin
      st_nxt.busy = 1'b1;
      st_nxt.go = 1'b1;
      st_nxt.cnt = 7'd0;
      st_nxt.emph = 3'd0;
      st_nxt.ch = wr_ctrl0 ? hwdata[CH_LSB +: 3] : first_ch;
      if (mode_type'(st_nxt.ctrl0[MODE_LSB +: 3]) != MODE_ONESHOT &&
          mode_type'(st_nxt.ctrl0[MODE_LSB +: 3]) != MODE_REPEAT) begin
        st_nxt.ch = 3'd0;
      end
      st_nxt.other = {1'b0, st_nxt.ctrl1[SWEEP_LSB +: 2]} + 3'd1;
    end
    // read data prepared in the address phase, shown in the data phase
    st_nxt.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      if (rd_idx == IDX_CTRL0) begin
        st_nxt.rdata = {24'h00_0000, st_r.ctrl0};
      end else if (rd_idx == IDX_CTRL1) begin
        st_nxt.rdata = {24'h00_0000, st_r.ctrl1};
      end else if (rd_idx == IDX_CTRL2) begin
        st_nxt.rdata = {31'h0000_0000, st_r.sh};
      end else if (rd_idx == IDX_STATUS) begin
        st_nxt.rdata = {28'h000_0000, st_r.ch, st_r.busy};
      end else if (rd_idx[9:4] == IDX_RESULT_HI) begin
        // readable at any time; each result word changes in one cycle
        st_nxt.rdata = rd_idx[0] ? {30'h0, st_r.res[rd_idx[3:1]][9:8]}
                                 : {24'h00_0000, st_r.res[rd_idx[3:1]][7:0]};
      end
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.ctrl0 <= CTRL0_RST;
      st_r.ctrl1 <= CTRL1_RST;
      st_r.sh <= CTRL2_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register, except hreadyout and hresp which are tied constant
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign analog_sel = st_r.ch;
  assign sar_go = st_r.go;
  assign sar_sh = st_r.sh;
  assign sar_res10 = st_r.ctrl1[RES10_BIT];
  assign conv_tick = st_r.tick;
  assign vref_connect = st_r.ctrl1[VREF_BIT];
  assign conv_irq = st_r.irq;

  sequence sw_start_seq;
    st_r.wr_pend && st_r.wr_idx == IDX_CTRL0 && hwdata[START_BIT] && !hwdata[EXT_BIT]
      && !st_r.ctrl0[START_BIT];
  endsequence

  sequence ext_fall_seq;
    st_r.ctrl0[EXT_BIT] && st_r.ctrl0[START_BIT] && st_r.trig_d && !st_r.trig_s
      && !st_r.wr_pend;
  endsequence

  AST_IRQ_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_irq |=> !conv_irq) else $error("interrupt longer than one cycle");

  AST_SW_START: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_start_seq |=> st_r.busy && sar_go && st_r.cnt == 7'd0) else $error("software start lost");

  AST_EXT_START: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_fall_seq |=> st_r.busy && sar_go) else $error("trigger edge did not start");

  AST_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.wr_pend && st_r.wr_idx == IDX_CTRL0 && !hwdata[START_BIT] |=> !st_r.busy && !sar_go)
    else $error("zero start flag did not stop");

  AST_END_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_irq && !st_r.ctrl0[EXT_BIT] && !$past(st_r.wr_pend) |-> !st_r.ctrl0[START_BIT]
      && !st_r.busy) else $error("start flag not cleared at end");

  AST_NO_IRQ_REPEAT: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(st_r.busy) && $past(mode) != MODE_ONESHOT && $past(mode) != MODE_SWEEP |-> !conv_irq)
    else $error("interrupt in a repeating mode");

  AST_CNT_BOUND: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.busy |-> st_r.cnt < conv_cycles(st_r.sh, st_r.ctrl1[RES10_BIT]))
    else $error("conversion ran past its cycle count");

  AST_SWEEP_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.busy && (mode == MODE_SWEEP || mode == MODE_RSWEEP0) |->
      {1'b0, st_r.ch} < group_len(st_r.ctrl1[SWEEP_LSB +: 2]))
    else $error("sweep left its input group");

  // a rest input finishing in repeat sweep 1 must hand back to the first input
  sequence rs1_rest_done_seq;
    st_r.busy && st_r.tick && st_r.cnt == cyc - 7'd1 && !st_r.wr_pend
      && mode == MODE_RSWEEP1 && st_r.ch > emph_top;
  endsequence

  AST_RS1_EMPH: assert property (@(posedge hclk) disable iff (!hresetn)
    rs1_rest_done_seq |=> sar_go && analog_sel == 3'd0) else $error("emphasis order broken");

endmodule

// file: bench/adc_front_model.sv
/*
  Far-side model: analog value per input and the trigger pin.
  Assumes the engine samples within cyc+2 ticks of sar_go; later the value is inverted.
*/
`timescale 1ns/1ps
module adc_front_model (
  input wire logic hclk,
  input wire logic [2:0] analog_sel,
  input wire logic sar_go,
  input wire logic conv_tick,
  input wire logic [9:0] base,
  input wire logic [6:0] cyc,
  input wire logic fire,
  output logic [9:0] sar_result,
  output logic conv_ext_trigger
);
  logic [2:0] ch_r = 3'h0;
  logic [7:0] cnt_r = 8'hff;
  logic [3:0] low_r = 4'h0;
  logic [9:0] val;
  // value per input; inverted once no conversion may sample it, so stale use shows
  assign val = base ^ {ch_r, ch_r, ch_r, 1'b1};
  assign sar_result = (cnt_r <= {1'b0, cyc} + 8'h02) ? val : ~val;
  // pin idles high like a pulled-up line; fire gives one falling edge
  assign conv_ext_trigger = (low_r == 4'h0);
  // latch input at each start, count ticks until the value expires
  always @(posedge hclk) begin
    if (sar_go) begin
      ch_r <= analog_sel;
      cnt_r <= 8'h00;
    end else if (conv_tick && cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
    low_r <= fire ? 4'h6 : (low_r != 4'h0 ? low_r - 4'h1 : 4'h0);
  end
endmodule

// file: bench/adc_sequencer_control_bench.sv
/*
  Self-checking bench: AHB-Lite master, random mode runs, result and order checks.
  Assumes zero-wait slave and converter clock from the selected source.
*/
`timescale 1ns/1ps
module adc_sequencer_control_bench
  import adc_seq_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fire = 0, conv_xin = 0, hready;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, analog_sel;
  logic [31:0] hwdata = 0, hrdata;
  logic [9:0] base = 0, sar_result;
  logic [6:0] cyc = 0;
  logic hreadyout, hresp, conv_ext_trigger, sar_go, sar_sh, sar_res10, conv_tick;
  logic vref_connect, conv_irq;
  logic [2:0] goq[$];
  int gapq[$];
  int tick_cnt = 0, irq_cnt = 0, fail_count = 0, comparisons = 0;
  assign hready = hreadyout;
  adc_seq DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .conv_ext_trigger(conv_ext_trigger),
    .conv_xin(conv_xin),
    .sar_result(sar_result),
    .analog_sel(analog_sel),
    .sar_go(sar_go),
    .sar_sh(sar_sh),
    .sar_res10(sar_res10),
    .conv_tick(conv_tick),
    .vref_connect(vref_connect),
    .conv_irq(conv_irq)
  );
  adc_front_model model (
    .hclk(hclk),
    .analog_sel(analog_sel),
    .sar_go(sar_go),
    .conv_tick(conv_tick),
    .base(base),
    .cyc(cyc),
    .fire(fire),
    .sar_result(sar_result),
    .conv_ext_trigger(conv_ext_trigger)
  );
  initial begin
    forever #10 hclk = ~hclk;
  end
  // xin unrelated in phase to hclk
  initial begin
    forever #31 conv_xin = ~conv_xin;
  end
  // record input of each start and ticks between events
  always @(posedge hclk) begin
    if (hresetn) begin
      if (conv_tick === 1'b1) tick_cnt++;
      if (sar_go === 1'b1) goq.push_back(analog_sel);
      if (conv_irq === 1'b1) irq_cnt++;
      if (sar_go === 1'b1 || conv_irq === 1'b1) begin
        gapq.push_back(tick_cnt);
        tick_cnt = 0;
      end
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single word transfer; holds each phase until hready is sampled high
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    hsize <= 3'h2;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 50) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(nm, e, rd);
  endtask
  // bounded wait for n starts or for an interrupt
  task automatic waitc(input int n, input bit irq);
    int k;
    for (k = 0; k < 40000 && (irq ? irq_cnt == 0 : goq.size() < n); k++) @(posedge hclk);
    if (k >= 40000) begin
      fail_count++;
      finish_test();
    end
  endtask
  function automatic logic [2:0] exp_ch(mode_type m, logic [2:0] ch, logic [1:0] g, int i);
    int k;
    k = g + 1;
    case (m)
      MODE_SWEEP, MODE_RSWEEP0: return 3'(i % (2 * k));
      MODE_RSWEEP1: return 3'((i % (k + 1) < k) ? i % (k + 1) : k + (i / (k + 1)) % (8 - k));
      default: return ch;
    endcase
  endfunction
  task automatic run(input mode_type m, input logic ext);
    logic [2:0] ch, c;
    logic [1:0] grp, clk;
    logic res, sh;
    logic [9:0] b, v;
    logic [31:0] d;
    int n, want, n0;
    ch = 3'($urandom);
    grp = 2'($urandom);
    clk = 2'($urandom);
    res = 1'($urandom);
    sh = 1'($urandom);
    b = 10'($urandom);
    n = sh ? (res ? CYC_SH_10 : CYC_SH_8) : (res ? CYC_10 : CYC_8);
    base <= b;
    cyc <= 7'(n);
    d = {24'h0, 1'b0, ext, m, ch};
    wr(IDX_CTRL2, {31'h0, sh});
    wr(IDX_CTRL1, {24'h0, clk, 1'b1, 1'b0, res, 1'b0, grp});
    wr(IDX_CTRL0, d);
    chk("res10", res, sar_res10);
    chk("hold", sh, sar_sh);
    goq.delete();
    gapq.delete();
    irq_cnt = 0;
    wr(IDX_CTRL0, d | 32'h80);
    if (ext) begin
      repeat (20) @(posedge hclk);
      chk("idle", 0, goq.size());
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
    end
    if (m == MODE_ONESHOT || m == MODE_SWEEP) begin
      want = (m == MODE_ONESHOT) ? 1 : 2 * (grp + 1);
      waitc(want, 1'b1);
      repeat (3) @(posedge hclk);
      chk("irq", 1, irq_cnt);
      chk("starts", want, goq.size());
      rdchk("start", IDX_CTRL0, d | {24'h0, ext, 7'h0});
      if (m == MODE_ONESHOT) rdchk("status", IDX_STATUS, {28'h0, ch, 1'b0});
    end else begin
      want = 5;
      waitc(6, 1'b0);
      wr(IDX_CTRL0, d);
      repeat (5) @(posedge hclk);
      n0 = goq.size();
      repeat (300) @(posedge hclk);
      chk("stopped", n0, goq.size());
      chk("irq", 0, irq_cnt);
    end
    for (int i = 0; i < want; i++) begin
      chk("order", exp_ch(m, ch, grp, i), goq[i]);
      chk("ticks", 1, gapq[i + 1] >= n - 1 && gapq[i + 1] <= n + 1);
      c = goq[i];
      v = b ^ {c, c, c, 1'b1};
      rdchk("even", {IDX_RESULT_HI, c, 1'b0}, res ? v[7:0] : v[9:2]);
      rdchk("odd", {IDX_RESULT_HI, c, 1'b1}, res ? v[9:8] : 2'h0);
    end
  endtask
  initial begin
    void'($urandom(58504));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl0", IDX_CTRL0, CTRL0_RST);
    rdchk("ctrl1", IDX_CTRL1, CTRL1_RST);
    rdchk("ctrl2", IDX_CTRL2, CTRL2_RST);
    rdchk("unmapped", 10'h200, 32'h0);
    wr(IDX_CTRL1, 32'h20);
    repeat (50) @(posedge hclk);
    chk("vref", 1, vref_connect);
    for (int m = 0; m < 5; m++) repeat (2) run(mode_type'(m), 1'b0);
    run(MODE_ONESHOT, 1'b1);
    run(MODE_SWEEP, 1'b1);
    wr(IDX_CTRL1, 32'h0);
    @(posedge hclk);
    chk("vref", 0, vref_connect);
    finish_test();
  end
endmodule
